// [core/fmac_pkg.sv]
// Shared constants and types for the frame memory address counter.
package fmac_pkg;
    // Frame geometry.
    localparam logic [8:0] COL_LAST = 9'h13F;
    localparam logic [8:0] PAGE_LAST = 9'h1DF;
    localparam logic [8:0] PANEL_LINES = 9'h1E0;
    localparam int unsigned PIX_W = 18;
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned MEM_DEPTH = 153600;
    localparam int unsigned BUF_DEPTH = 2;
    // Register byte offsets.
    localparam logic [7:0] OFF_ACCESS = 8'h00;
    localparam logic [7:0] OFF_COLUMN = 8'h04;
    localparam logic [7:0] OFF_PAGE = 8'h08;
    localparam logic [7:0] OFF_PARAM_A = 8'h0C;
    localparam logic [7:0] OFF_PARAM_B = 8'h10;
    localparam logic [7:0] OFF_CMD = 8'h14;
    localparam logic [7:0] OFF_PIXEL = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    // Field positions inside a register word.
    localparam int unsigned LO_LSB = 0;
    localparam int unsigned HI_LSB = 16;
    localparam int unsigned ACCESS_LSB = 4;
    // Command codes written to the command register.
    localparam logic [7:0] CMD_MEM_WRITE = 8'h2C;
    localparam logic [7:0] CMD_MEM_READ = 8'h2E;
    localparam logic [7:0] CMD_SCROLL_DEF = 8'h33;
    localparam logic [7:0] CMD_SCROLL_START = 8'h37;
    // Memory access control bits, top bit first.
    typedef struct packed {
        logic row_mirror;
        logic column_mirror;
        logic row_column_exchange;
        logic vertical_refresh_order;
    } access_t;
    typedef struct packed {
        logic [8:0] start_column;
        logic [8:0] end_column;
        logic [8:0] start_page;
        logic [8:0] end_page;
    } window_t;
    typedef struct packed {
        logic [8:0] top_fixed_area;
        logic [8:0] scroll_area_height;
        logic [8:0] bottom_fixed_area;
        logic [8:0] scroll_start_line;
    } scroll_t;
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b001,
        MODE_WRITE = 3'b010,
        MODE_READ = 3'b100
    } mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RAM = 3'b010,
        ST_ACK = 3'b100
    } bus_state_t;
    // Reset values.
    localparam access_t ACCESS_RST = 4'h0;
    localparam window_t WIN_RST = '{9'h000, COL_LAST, 9'h000, PAGE_LAST};
    localparam scroll_t SCROLL_RST = '{9'h000, PANEL_LINES, 9'h000, 9'h000};
endpackage : fmac_pkg

// [core/frame_memory_address_counter.sv]
// Address counter, register slave and scroll mapper of the frame memory.
`timescale 1ns/10ps
// Operation
// RULE1: Frame memory holds 320 columns by 480 pages of 18-bit pixels.
// RULE2: Panel reads and host reads or writes proceed together undisturbed.
// RULE3: Full display shows columns 0 to 13Fh and pages 0 to 1DFh.
// RULE4: Command 33h sets area sizes; command 37h sets scroll start line.
// RULE5: Host keeps top, scroll and bottom heights summing to 480.
// RULE6: Three access control bits map counters onto physical pointers.
// RULE7: Row mirror uses 479 minus page; column mirror 319 minus column.
// RULE8: Exchange swaps column and page axes; mirrors act on swapped axes.
// RULE9: Memory write or read command reloads both counters from starts.
// RULE10: Each complete pixel increments column counter; page stays.
// RULE11: Column past end column reloads start column, increments page.
// RULE12: Page past end page reloads start column and start page.
// RULE13: One pixel takes one column value and one page value.
// RULE14: Scroll area shows lines from start line, wrapping, order selectable.
module frame_memory_address_counter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone register slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Panel refresh read port
    input wire logic panel_req_i,
    input wire logic [8:0] panel_line_i,
    input wire logic [8:0] panel_col_i,
    output logic [17:0] panel_pixel_o,
    output logic panel_valid_o
);
    fmac_pkg::access_t acc_q, acc_d;
    fmac_pkg::window_t win_q, win_d;
    fmac_pkg::scroll_t scr_q, scr_d;
    fmac_pkg::mode_t mode_q, mode_d;
    fmac_pkg::bus_state_t state_q, state_d;
    logic [31:0] par_a_q, par_a_d, par_b_q, par_b_d, dat_q, dat_d;
    logic [8:0] col_q, col_d, page_q, page_d;
    logic panel_valid_q;
    logic req, take, stall, is_pix, is_cmd, wmode, rmode, pix_rd, step;
    logic [31:0] rd_word, wr_word;
    logic buf_in_valid, buf_in_ready, buf_out_valid, host_we, host_re;
    logic [17:0] buf_out_data, host_rdata, host_addr, panel_addr;
    logic [8:0] pc0, pp0, phys_col, phys_page, mem_line;
    logic [9:0] area_end, off, off2, sum;
    logic panel_re;

    // Byte-lane merge of a bus write into a register's current value.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction : merge

    // Linear word address of a physical page and column, page times 320.
    function automatic logic [17:0] lin_addr(input logic [8:0] pg,
                                             input logic [8:0] cl);
        return {1'b0, pg, 8'h00} + {3'h0, pg, 6'h00} + {9'h000, cl};
    endfunction : lin_addr

    // Request decode; a request waits while its resource is busy.
    always_comb begin
        req = wb_cyc_i && wb_stb_i;
        is_pix = (wb_adr_i == fmac_pkg::OFF_PIXEL);
        is_cmd = (wb_adr_i == fmac_pkg::OFF_CMD);
        wmode = (mode_q == fmac_pkg::MODE_WRITE);
        rmode = (mode_q == fmac_pkg::MODE_READ);
        stall = (is_pix && wb_we_i && wmode && !buf_in_ready)
              || (is_cmd && wb_we_i && buf_out_valid);
        take = req && (state_q == fmac_pkg::ST_IDLE) && !stall;
        pix_rd = is_pix && !wb_we_i && rmode;
        buf_in_valid = take && is_pix && wb_we_i && wmode;
        host_re = take && pix_rd;
        step = (buf_out_valid && wmode)
             || (state_q == fmac_pkg::ST_RAM); // RULE13
        wb_ack_o = (state_q == fmac_pkg::ST_ACK);
        wb_dat_o = dat_q;
    end

    // Current value of the addressed register; unmapped reads as zero.
    always_comb begin
        rd_word = 32'h00000000;
        case (wb_adr_i)
            fmac_pkg::OFF_ACCESS: rd_word = {24'h000000, acc_q, 4'h0};
            fmac_pkg::OFF_COLUMN: rd_word = {7'h00, win_q.end_column,
                                             7'h00, win_q.start_column};
            fmac_pkg::OFF_PAGE: rd_word = {7'h00, win_q.end_page,
                                           7'h00, win_q.start_page};
            fmac_pkg::OFF_PARAM_A: rd_word = par_a_q;
            fmac_pkg::OFF_PARAM_B: rd_word = par_b_q;
            fmac_pkg::OFF_CMD: rd_word = {29'h00000000, mode_q};
            fmac_pkg::OFF_STATUS: rd_word = {7'h00, page_q, 7'h00, col_q};
            default: rd_word = 32'h00000000;
        endcase
        wr_word = merge(rd_word, wb_dat_i, wb_sel_i);
    end

    // Logical counters onto physical pointers.
    always_comb begin
        pc0 = acc_q.row_column_exchange ? page_q : col_q; // RULE8
        pp0 = acc_q.row_column_exchange ? col_q : page_q; // RULE8
        phys_col = acc_q.column_mirror ? fmac_pkg::COL_LAST - pc0
                                       : pc0; // RULE7
        phys_page = acc_q.row_mirror ? fmac_pkg::PAGE_LAST - pp0
                                     : pp0; // RULE7
        host_addr = lin_addr(phys_page, phys_col); // RULE6
        host_we = buf_out_valid && wmode
               && (phys_col <= fmac_pkg::COL_LAST)
               && (phys_page <= fmac_pkg::PAGE_LAST);
    end

    // Panel line through the vertical scroll areas.
    always_comb begin
        area_end = {1'b0, scr_q.top_fixed_area}
                 + {1'b0, scr_q.scroll_area_height};
        off = {1'b0, panel_line_i} - {1'b0, scr_q.top_fixed_area};
        off2 = acc_q.vertical_refresh_order
             ? {1'b0, scr_q.scroll_area_height} - off - 10'h001 : off;
        sum = {1'b0, scr_q.scroll_start_line} + off2;
        if (sum >= area_end) begin
            sum = sum - {1'b0, scr_q.scroll_area_height}; // RULE14
        end
        mem_line = panel_line_i;
        if (panel_line_i >= scr_q.top_fixed_area
            && {1'b0, panel_line_i} < area_end) begin
            mem_line = sum[8:0]; // RULE14
        end
        panel_re = panel_req_i && (panel_line_i <= fmac_pkg::PAGE_LAST)
                && (panel_col_i <= fmac_pkg::COL_LAST); // RULE3
        panel_addr = lin_addr(mem_line, panel_col_i);
        panel_valid_o = panel_valid_q;
    end

    // Next values of bus state, registers and counters.
    always_comb begin
        acc_d = acc_q;
        win_d = win_q;
        scr_d = scr_q;
        par_a_d = par_a_q;
        par_b_d = par_b_q;
        mode_d = mode_q;
        col_d = col_q;
        page_d = page_q;
        state_d = state_q;
        dat_d = dat_q;
        unique case (state_q)
            fmac_pkg::ST_IDLE: begin
                if (take) begin
                    dat_d = rd_word;
                    state_d = pix_rd ? fmac_pkg::ST_RAM : fmac_pkg::ST_ACK;
                end
            end
            fmac_pkg::ST_RAM: begin
                dat_d = {14'h0000, host_rdata};
                state_d = fmac_pkg::ST_ACK;
            end
            fmac_pkg::ST_ACK: state_d = fmac_pkg::ST_IDLE;
            default: state_d = fmac_pkg::ST_IDLE;
        endcase
        if (take && wb_we_i) begin
            case (wb_adr_i)
                fmac_pkg::OFF_ACCESS: begin
                    acc_d = wr_word[fmac_pkg::ACCESS_LSB +: 4]; // RULE6
                end
                fmac_pkg::OFF_COLUMN: begin
                    win_d.start_column = wr_word[fmac_pkg::LO_LSB +: 9];
                    win_d.end_column = wr_word[fmac_pkg::HI_LSB +: 9];
                end
                fmac_pkg::OFF_PAGE: begin
                    win_d.start_page = wr_word[fmac_pkg::LO_LSB +: 9];
                    win_d.end_page = wr_word[fmac_pkg::HI_LSB +: 9];
                end
                fmac_pkg::OFF_PARAM_A: par_a_d = wr_word;
                fmac_pkg::OFF_PARAM_B: par_b_d = wr_word;
                fmac_pkg::OFF_CMD: begin
                    if (wr_word[7:0] == fmac_pkg::CMD_MEM_WRITE
                        || wr_word[7:0] == fmac_pkg::CMD_MEM_READ) begin
                        mode_d = (wr_word[7:0] == fmac_pkg::CMD_MEM_WRITE)
                               ? fmac_pkg::MODE_WRITE
                               : fmac_pkg::MODE_READ;
                        col_d = win_q.start_column; // RULE9
                        page_d = win_q.start_page; // RULE9
                    end else if (wr_word[7:0] == fmac_pkg::CMD_SCROLL_DEF)
                    begin
                        scr_d.top_fixed_area =
                            par_a_q[fmac_pkg::LO_LSB +: 9]; // RULE4
                        scr_d.scroll_area_height =
                            par_a_q[fmac_pkg::HI_LSB +: 9];
                        scr_d.bottom_fixed_area =
                            par_b_q[fmac_pkg::LO_LSB +: 9];
                    end else if (wr_word[7:0] == fmac_pkg::CMD_SCROLL_START)
                    begin
                        scr_d.scroll_start_line =
                            par_b_q[fmac_pkg::HI_LSB +: 9]; // RULE4
                    end else begin
                        mode_d = fmac_pkg::MODE_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
        if (step) begin
            if (col_q >= win_q.end_column) begin
                col_d = win_q.start_column; // RULE11
                if (page_q >= win_q.end_page) begin
                    page_d = win_q.start_page; // RULE12
                end else begin
                    page_d = page_q + 9'h001; // RULE11
                end
            end else begin
                col_d = col_q + 9'h001; // RULE10
            end
        end
    end

    // State registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_q <= fmac_pkg::ACCESS_RST;
            win_q <= fmac_pkg::WIN_RST; // RULE3
            scr_q <= fmac_pkg::SCROLL_RST;
            par_a_q <= 32'h00000000;
            par_b_q <= 32'h00000000;
            mode_q <= fmac_pkg::MODE_IDLE;
            col_q <= 9'h000;
            page_q <= 9'h000;
            state_q <= fmac_pkg::ST_IDLE;
            dat_q <= 32'h00000000;
            panel_valid_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            win_q <= win_d;
            scr_q <= scr_d;
            par_a_q <= par_a_d;
            par_b_q <= par_b_d;
            mode_q <= mode_d;
            col_q <= col_d;
            page_q <= page_d;
            state_q <= state_d;
            dat_q <= dat_d;
            panel_valid_q <= panel_re;
        end
    end

    // Two-entry buffer decouples bus writes from memory writes.
    pixel_buffer #(
        .WIDTH(fmac_pkg::PIX_W),
        .DEPTH(fmac_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(buf_in_valid),
        .in_data_i(wb_dat_i[17:0]),
        .in_ready_o(buf_in_ready),
        .out_valid_o(buf_out_valid),
        .out_data_o(buf_out_data),
        .out_ready_i(wmode)
    );

    // Frame storage.
    frame_ram u_ram (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .a_we_i(host_we),
        .a_re_i(host_re),
        .a_addr_i(host_addr),
        .a_wdata_i(buf_out_data),
        .a_rdata_o(host_rdata),
        .b_re_i(panel_re),
        .b_addr_i(panel_addr),
        .b_rdata_o(panel_pixel_o)
    );

    // Checks of the counter, mapping and bus behaviour.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_cmd(logic [7:0] code);
        take && wb_we_i && is_cmd && wr_word[7:0] == code;
    endsequence
    sequence s_pix_rd;
        take && pix_rd;
    endsequence

    property p_reload;
        s_cmd(fmac_pkg::CMD_MEM_WRITE) |=> col_q == $past(win_q.start_column)
            && page_q == $past(win_q.start_page) && wmode;
    endproperty
    a_reload: assert property (p_reload) else $error("reload failed"); // RULE9
    property p_col_inc;
        step && col_q < win_q.end_column
            |=> col_q == $past(col_q) + 9'h001 && page_q == $past(page_q);
    endproperty
    a_col_inc: assert property (p_col_inc) else $error("no step"); // RULE10
    property p_col_wrap;
        step && col_q >= win_q.end_column && page_q < win_q.end_page
            |=> col_q == $past(win_q.start_column)
            && page_q == $past(page_q) + 9'h001;
    endproperty
    a_col_wrap: assert property (p_col_wrap) else $error("bad wrap"); // RULE11
    property p_page_wrap;
        step && col_q >= win_q.end_column && page_q >= win_q.end_page
            |=> page_q == $past(win_q.start_page);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("no wrap"); // RULE12
    property p_row_mirror;
        acc_q.row_mirror && !acc_q.row_column_exchange
            |-> phys_page == fmac_pkg::PAGE_LAST - page_q;
    endproperty
    a_row_mirror: assert property (p_row_mirror) else $error("page"); // RULE7
    property p_exchange;
        acc_q.row_column_exchange && !acc_q.column_mirror
            |-> phys_col == page_q && (acc_q.row_mirror || phys_page == col_q);
    endproperty
    a_exchange: assert property (p_exchange) else $error("swap"); // RULE8
    property p_read_pixel;
        s_pix_rd |=> step ##1 wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_read_pixel: assert property (p_read_pixel) else $error("read"); // RULE10
    property p_panel;
        panel_re && panel_line_i < scr_q.top_fixed_area
            |-> mem_line == panel_line_i ##1 panel_valid_o;
    endproperty
    a_panel: assert property (p_panel) else $error("panel read"); // RULE2
    property p_scroll_start;
        s_cmd(fmac_pkg::CMD_SCROLL_START)
            |=> scr_q.scroll_start_line == $past(par_b_q[24:16]);
    endproperty
    a_scroll_start: assert property (p_scroll_start) else $error("37"); // RULE4
endmodule : frame_memory_address_counter

// [core/frame_ram.sv]
// Frame memory with a host port and an independent panel read port.
`timescale 1ns/10ps
module frame_ram (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Host port
    input wire logic a_we_i,
    input wire logic a_re_i,
    input wire logic [17:0] a_addr_i,
    input wire logic [17:0] a_wdata_i,
    output logic [17:0] a_rdata_o,
    // Panel port
    input wire logic b_re_i,
    input wire logic [17:0] b_addr_i,
    output logic [17:0] b_rdata_o
);
    logic [17:0] mem [fmac_pkg::MEM_DEPTH]; // RULE1

    // Storage write from the host port.
    always_ff @(posedge clk_i) begin
        if (a_we_i) begin
            mem[a_addr_i] <= a_wdata_i;
        end
    end

    // Both ports read in the same cycle without blocking each other.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_rdata_o <= 18'h00000;
            b_rdata_o <= 18'h00000;
        end else begin
            if (a_re_i) begin
                a_rdata_o <= mem[a_addr_i];
            end
            if (b_re_i) begin
                b_rdata_o <= mem[b_addr_i]; // RULE2
            end
        end
    end
endmodule : frame_ram

// [core/pixel_buffer.sv]
// Small first-in first-out buffer for pixel words.
`timescale 1ns/10ps
module pixel_buffer #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Filling side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Draining side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;

    // Handshakes and pointer updates.
    always_comb begin
        in_ready_o = (cnt_q != CNT_FULL);
        out_valid_o = (cnt_q != '0);
        out_data_o = mem_q[rd_q];
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
        end
        cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    // Pointer and count registers; entries hold no reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
endmodule : pixel_buffer

// [verif/frame_memory_address_counter_tb_top.sv]
// Self-checking bench for the frame memory address counter.
`timescale 1ns/10ps
module frame_memory_address_counter_tb_top;
    // Clock, reset, port signals and bookkeeping.
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req = 1'b0;
    logic cyc, stb, we, ack, pv;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, rd, q;
    logic [8:0] pl = 9'h000;
    logic [8:0] pc = 9'h000;
    logic [17:0] pp;
    logic [17:0] px [0:3];
    int n_fail = 0;
    int cmp_count = 0;
    int seed = 89941;
    // Clock at 100 MHz.
    always #5 clk_i = ~clk_i;
    frame_memory_address_counter frame_memory_address_counter_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(rd), .wb_ack_o(ack), .panel_req_i(req),
        .panel_line_i(pl), .panel_col_i(pc), .panel_pixel_o(pp),
        .panel_valid_o(pv));
    host_model host_model_inst (
        .clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wd), .dat_i(rd), .ack_i(ack));
    // Comparison, bus and panel helpers.
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host_model_inst.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        host_model_inst.xfer(1'b0, a, 32'h0, q);
        check(nm, q, e);
    endtask : rdc
    task automatic panel(input logic [8:0] l, input logic [8:0] c,
                         output logic [31:0] got);
        @(posedge clk_i);
        req <= 1'b1;
        pl <= l;
        pc <= c;
        @(posedge clk_i);
        req <= 1'b0;
        pl <= ~l;
        pc <= ~c;
        #1;
        got = {13'h0, pv, pp};
    endtask : panel
    // Status word after k pixels in the window of columns 2..3, pages 5..6.
    function automatic logic [31:0] stat(input int k);
        return {7'h0, 9'(5 + (k / 2) % 2), 7'h0, 9'(2 + k % 2)};
    endfunction : stat
    // Physical page and column of a counter position under access bits m.
    function automatic logic [17:0] where(input logic [2:0] m,
                                          input logic [8:0] c,
                                          input logic [8:0] p);
        logic [8:0] x, y;
        x = m[0] ? p : c;
        y = m[0] ? c : p;
        if (m[1]) x = fmac_pkg::COL_LAST - x;
        if (m[2]) y = fmac_pkg::PAGE_LAST - y;
        return {y, x};
    endfunction : where
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    // Watchdog that ends a hung run.
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
    // Main sequence.
    initial begin
        logic [31:0] got;
        logic [17:0] d, a;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("col", fmac_pkg::OFF_COLUMN, 32'h013F0000);
        rdc("page", fmac_pkg::OFF_PAGE, 32'h01DF0000);
        rdc("stat", fmac_pkg::OFF_STATUS, 32'h0);
        rdc("mode", fmac_pkg::OFF_CMD, 32'h1);
        rdc("unmapped", 8'h20, 32'h0);
        rdc("pix idle", fmac_pkg::OFF_PIXEL, 32'h0);
        // Two by two window written with wrap of column, page and window.
        wr(fmac_pkg::OFF_COLUMN, 32'h00030002);
        wr(fmac_pkg::OFF_PAGE, 32'h00060005);
        wr(fmac_pkg::OFF_CMD, {24'h0, fmac_pkg::CMD_MEM_WRITE});
        rdc("start", fmac_pkg::OFF_STATUS, 32'h00050002);
        for (int i = 0; i < 4; i++) begin
            px[i] = 18'($random(seed));
            wr(fmac_pkg::OFF_PIXEL, {14'h0, px[i]});
            rdc("step", fmac_pkg::OFF_STATUS,
                stat(i + 1));
        end
        // Panel reads the first pixel while the host reads the mode register; then read back.
        wr(fmac_pkg::OFF_CMD, {24'h0, fmac_pkg::CMD_MEM_READ});
        fork
            panel(9'h005, 9'h002, got);
            rdc("mode rd", fmac_pkg::OFF_CMD, 32'h4);
        join
        check("panel", got, {13'h0, 1'b1, px[0]});
        for (int i = 0; i < 4; i++) begin
            rdc("rdback", fmac_pkg::OFF_PIXEL, {14'h0, px[i]});
        end
        // All eight orientations of one pixel at column 1, page 2.
        wr(fmac_pkg::OFF_COLUMN, 32'h00010001);
        wr(fmac_pkg::OFF_PAGE, 32'h00020002);
        for (int m = 0; m < 8; m++) begin
            d = 18'($random(seed));
            wr(fmac_pkg::OFF_ACCESS, 32'(m) << 5);
            wr(fmac_pkg::OFF_CMD, {24'h0, fmac_pkg::CMD_MEM_WRITE});
            wr(fmac_pkg::OFF_PIXEL, {14'h0, d});
            a = where(3'(m), 9'h001, 9'h002);
            panel(a[17:9], a[8:0], got);
            check("orient", got, {13'h0, 1'b1, d});
        end
        // Scroll by 40 lines: memory page 2 shows on display line 442.
        wr(fmac_pkg::OFF_ACCESS, 32'h0);
        wr(fmac_pkg::OFF_CMD, {24'h0, fmac_pkg::CMD_MEM_WRITE});
        wr(fmac_pkg::OFF_PIXEL, {14'h0, d});
        wr(fmac_pkg::OFF_PARAM_A, 32'h01E00000);
        wr(fmac_pkg::OFF_PARAM_B, 32'h00280000);
        wr(fmac_pkg::OFF_CMD, {24'h0, fmac_pkg::CMD_SCROLL_DEF});
        wr(fmac_pkg::OFF_CMD, {24'h0, fmac_pkg::CMD_SCROLL_START});
        panel(9'h1BA, 9'h001, got);
        check("scroll", got, {13'h0, 1'b1, d});
        panel(9'h1E0, 9'h001, got);
        check("range", {31'h0, got[18]}, 32'h0);
        // Top fixed area of 30 lines; scroll area of 450 starts at line 80.
        d = 18'($random(seed));
        wr(fmac_pkg::OFF_PAGE, 32'h00500050);
        wr(fmac_pkg::OFF_CMD, {24'h0, fmac_pkg::CMD_MEM_WRITE});
        wr(fmac_pkg::OFF_PIXEL, {14'h0, d});
        wr(fmac_pkg::OFF_PARAM_A, 32'h01C2001E);
        wr(fmac_pkg::OFF_PARAM_B, 32'h00500000);
        wr(fmac_pkg::OFF_CMD, {24'h0, fmac_pkg::CMD_SCROLL_DEF});
        wr(fmac_pkg::OFF_CMD, {24'h0, fmac_pkg::CMD_SCROLL_START});
        panel(9'h005, 9'h002, got);
        check("fixed", got, {13'h0, 1'b1, px[0]});
        panel(9'h01E, 9'h001, got);
        check("scroll top", got, {13'h0, 1'b1, d});
        // Reversed refresh order shows memory line 80 on display line 479.
        wr(fmac_pkg::OFF_ACCESS, 32'h10);
        panel(9'h1DF, 9'h001, got);
        check("reverse", got, {13'h0, 1'b1, d});
        // An unknown command code drops the block back to idle.
        wr(fmac_pkg::OFF_CMD, 32'h0);
        rdc("mode off", fmac_pkg::OFF_CMD, 32'h1);
        close_out();
    end
endmodule : frame_memory_address_counter_tb_top

// [verif/host_model.sv]
// Wishbone host model that drives the register port of the block.
`timescale 1ns/10ps
module host_model (
    // Clock
    input wire logic clk_i,
    // Wishbone master side
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic [31:0] dat_i,
    input wire logic ack_i
);
    // The bus starts idle with no request pending.
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'hFF;
        sel_o = 4'hF;
        dat_o = 32'h0;
    end
    // One classic cycle; released address and data lines show the inverse of their last value.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= d;
        // Only the bench watchdog ends a wait that never sees ack.
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        adr_o <= ~a;
        dat_o <= ~d;
    endtask : xfer
endmodule : host_model
